//--- rtl/uart_cfg.svh
// offsets, field positions, reset values and timing counts of the uart
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
`define OFS_DATA      8'h00
`define OFS_IER       8'h04
`define OFS_IIR       8'h08
`define OFS_LCR       8'h0C
`define OFS_LSR       8'h10
`define OFS_DIV       8'h14
`define OFS_CLK       8'h18
`define IER_RX        0
`define IER_THRE      1
`define IER_LS        2
`define FCR_EN        0
`define FCR_RXCLR     1
`define FCR_TXCLR     2
`define FCR_TRIG      7:6
`define IER_RST       3'h0
`define LCR_RST       6'h03
`define DIV_RST       16'h0001
`define IID_NONE      4'h0
`define IID_LS        4'h1
`define IID_RDA       4'h2
`define IID_TO        4'h3
`define IID_THRE      4'h4
`define TRIG_L0       5'h01
`define TRIG_L1       5'h04
`define TRIG_L2       5'h08
`define TRIG_L3       5'h0E
`define FIFO_DEPTH    5'h10
`define HCLK_MHZ      5'h19
`define SRC_FAST_MHZ  5'h18
`define SRC_SLOW_MHZ  5'h10
`define TMO_TICKS     10'h280
`endif

//--- rtl/uart_pkg.sv
// shared types and parity helper of the uart
package uart_pkg;
    typedef struct packed {
        logic       stick;
        logic       even;
        logic       par_en;
        logic       stop2;
        logic [1:0] wlen;
    } line_cfg_t;
    typedef struct packed {
        logic [1:0] trig;
        logic       en;
    } fifo_cfg_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
        tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
        rx_state_t;
    function automatic logic par_calc(line_cfg_t c, logic [7:0] d);
        logic [7:0] m;
        m = d & (8'hFF >> ~c.wlen);
        return c.stick ? ~c.even : ((^m) ^ ~c.even);
    endfunction : par_calc
endpackage : uart_pkg

//--- rtl/uart_tx.sv
// serial transmitter: framing and bit timing
`timescale 1ns/1ps
module uart_tx
(
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // timing and format
    input  wire logic                 tick,
    input  wire uart_pkg::line_cfg_t  cfg,
    // character source
    input  wire logic                 data_valid,
    input  wire logic [7:0]           data,
    output logic                      pop,
    output logic                      busy,
    // serial output
    output logic                      txd
);
    import uart_pkg::*;
    tx_state_t    state;
    tx_state_t    next_state;
    logic  [4:0]  ticks;
    logic  [2:0]  idx;
    logic  [7:0]  sh;
    logic         pbit;
    wire   [4:0]  stop_last = !cfg.stop2 ? 5'h0F :
                              (cfg.wlen == 2'h0) ? 5'h17 : 5'h1F;
    wire          bit_end = tick && (ticks ==
                            ((state == TX_STOP) ? stop_last : 5'h0F));
    wire          line    = (state == TX_START) ? 1'b0 :
                            (state == TX_DATA)  ? sh[0] :
                            (state == TX_PAR)   ? pbit : 1'b1;
    assign pop  = (state == TX_IDLE) && data_valid;
    assign busy = state != TX_IDLE;
    always_comb
    begin
        next_state = state;
        case (state)
            TX_IDLE:  if (data_valid) next_state = TX_START;
            TX_START: if (bit_end) next_state = TX_DATA;
            TX_DATA:  if (bit_end && idx == {1'b1, cfg.wlen})
                          next_state = cfg.par_en ? TX_PAR : TX_STOP;
            TX_PAR:   if (bit_end) next_state = TX_STOP;
            TX_STOP:  if (bit_end) next_state = TX_IDLE;
            default:  next_state = TX_IDLE;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= TX_IDLE;
            ticks <= 5'h00;
            idx   <= 3'h0;
            sh    <= 8'h00;
            pbit  <= 1'b0;
            txd   <= 1'b1;
        end
        else
        begin
            txd   <= line; // R11
            state <= next_state; // R10
            ticks <= (next_state != state || bit_end) ? 5'h00 :
                     tick ? ticks + 5'h01 : ticks; // R11
            if (pop)
            begin
                sh   <= data;
                pbit <= par_calc(cfg, data); // R3
                idx  <= 3'h0;
            end
            else if (bit_end && state == TX_DATA)
            begin
                sh  <= sh >> 1; // R1
                idx <= idx + 3'h1;
            end
        end
    end
    property p_tx_start;
        @(posedge hclk) disable iff (!hresetn)
        (state == TX_IDLE && data_valid) |-> ##2 !txd;
    endproperty
    a_tx_start: assert property (p_tx_start) // R2
        else $error("start bit not driven low");
    property p_tx_stop;
        @(posedge hclk) disable iff (!hresetn)
        (state == TX_STOP) |-> ##1 txd;
    endproperty
    a_tx_stop: assert property (p_tx_stop) // R11
        else $error("stop bit not high");
endmodule : uart_tx

//--- rtl/uart_rx.sv
// serial receiver: pin sync, glitch filter, framing and checks
`timescale 1ns/1ps
module uart_rx
(
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // timing and format
    input  wire logic                 tick,
    input  wire uart_pkg::line_cfg_t  cfg,
    // serial input
    input  wire logic                 rxd,
    // received character: framing error, parity error, data
    output logic                      push,
    output logic [9:0]                word
);
    import uart_pkg::*;
    rx_state_t    state;
    rx_state_t    next_state;
    logic         rx_meta;
    logic         rx_sync;
    logic         samp;
    logic         line;
    logic  [3:0]  ticks;
    logic  [2:0]  idx;
    logic  [7:0]  sh;
    logic         pbit;
    wire          mid  = tick && (ticks ==
                         ((state == RX_START) ? 4'h7 : 4'hF));
    wire   [7:0]  data = sh >> ~cfg.wlen;
    wire          last = idx == {1'b1, cfg.wlen};
    always_comb
    begin
        next_state = state;
        case (state)
            RX_IDLE:  if (tick && !line) next_state = RX_START;
            RX_START: if (mid) next_state = line ? RX_IDLE : RX_DATA;
            RX_DATA:  if (mid && last)
                          next_state = cfg.par_en ? RX_PAR : RX_STOP;
            RX_PAR:   if (mid) next_state = RX_STOP;
            RX_STOP:  if (mid) next_state = RX_IDLE;
            default:  next_state = RX_IDLE;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            samp    <= 1'b1;
            line    <= 1'b1;
            state   <= RX_IDLE;
            ticks   <= 4'h0;
            idx     <= 3'h0;
            sh      <= 8'h00;
            pbit    <= 1'b0;
            push    <= 1'b0;
            word    <= 10'h000;
        end
        else
        begin
            rx_meta <= rxd;
            rx_sync <= rx_meta;
            if (tick)
            begin
                samp <= rx_sync; // R14
                if (samp == rx_sync)
                    line <= rx_sync; // R15
            end
            state <= next_state;
            ticks <= (next_state != state) ? 4'h0 :
                     tick ? ticks + 4'h1 : ticks;
            if (state == RX_START)
                idx <= 3'h0;
            else if (mid && state == RX_DATA)
            begin
                sh  <= {line, sh[7:1]}; // R16
                idx <= idx + 3'h1;
            end
            if (mid && state == RX_PAR)
                pbit <= line;
            push <= mid && state == RX_STOP;
            if (mid && state == RX_STOP)
                word <= {!line, cfg.par_en && (pbit != par_calc(cfg, data)),
                         data}; // R17
        end
    end
    property p_rx_false_start;
        @(posedge hclk) disable iff (!hresetn)
        (state == RX_START && mid && line) |=> (state == RX_IDLE);
    endproperty
    a_rx_false_start: assert property (p_rx_false_start) // R15
        else $error("false start bit accepted");
    property p_rx_frame;
        @(posedge hclk) disable iff (!hresetn)
        (state == RX_STOP && mid && !line) |=> (push && word[9]);
    endproperty
    a_rx_frame: assert property (p_rx_frame) // R17
        else $error("missing stop bit not flagged");
endmodule : uart_rx

//--- rtl/uart_top.sv
// fifo uart top: ahb-lite registers, baud generator, fifos, interrupts
`timescale 1ns/1ps
`include "uart_cfg.svh"

// Summary of operation
// R1 - character length is programmable as five, six, seven or eight bits
// R2 - one start bit, then one, one and a half or two stop bits
// R3 - parity choice is even, odd, sticky fixed value or none
// R4 - pending interrupt causes are reported highest priority first
// R5 - baud divisor takes any value from 1 to 65535
// R6 - baud generator fed from a selectable 24 MHz or 16 MHz source
// R7 - 24 MHz source covers standard rates 50 up to 115.2 K
// R8 - 16 MHz source covers rates 125 K up to 1,000 K
// R9 - divisor can produce the MIDI data rate
// R10 - writing transmit data starts sending with configured framing
// R11 - start, data lsb first, parity, stop; sixteen baud clocks a bit
// R12 - transmit empty interrupt when holding register or fifo empties
// R13 - fifo enable bit 0; transmitter buffers 16 bytes, sends until empty
// R14 - receiver samples the line at baud clock divided by sixteen; the code samples it on every baud clock tick
// R15 - line pulses shorter than two receive clocks are ignored
// R16 - received data goes to buffer or fifo, first bit at bit 0
// R17 - received parity and stop bits are checked, mismatches flagged
// R18 - receive interrupt on data arrival, or fifo reaching trigger level
// R19 - interrupts for rx timeout, parity, framing and other line errors
// R20 - receive fifo buffers up to 16 bytes
// R21 - receive trigger level selectable as 1, 4, 8 or 14 bytes
// R22 - bit rate equals source clock over sixteen times divisor
module uart_top
(
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // ahb-lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic         hwrite,
    input  wire logic [1:0]   htrans,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    // serial link
    input  wire logic         rxd,
    output logic              txd,
    // interrupt request
    output logic              irq
);
    import uart_pkg::*;

    // software settings
    logic  [2:0]  ier;
    line_cfg_t    lcr;
    fifo_cfg_t    fcfg;
    logic [15:0]  divisor;
    logic         src_sel;

    // bus decode; writes land in the data phase
    logic         wr_pend;
    logic  [7:0]  wr_ofs;
    wire          ahb_ap  = hsel && hready && htrans[1];
    wire          ap_rd   = ahb_ap && !hwrite;
    wire   [7:0]  ap_ofs  = haddr[7:0];
    wire          wr_data = wr_pend && (wr_ofs == `OFS_DATA);
    wire          wr_ier  = wr_pend && (wr_ofs == `OFS_IER);
    wire          wr_fcr  = wr_pend && (wr_ofs == `OFS_IIR);
    wire          wr_lcr  = wr_pend && (wr_ofs == `OFS_LCR);
    wire          wr_div  = wr_pend && (wr_ofs == `OFS_DIV);
    wire          wr_clk  = wr_pend && (wr_ofs == `OFS_CLK);
    wire          rd_data = ap_rd && (ap_ofs == `OFS_DATA);
    wire          rd_iir  = ap_rd && (ap_ofs == `OFS_IIR);
    wire          rd_lsr  = ap_rd && (ap_ofs == `OFS_LSR);

    // source clock as a fractional enable: rate/25 of hclk
    logic  [4:0]  src_acc;
    logic         src_en;
    wire   [4:0]  src_rate = src_sel ? `SRC_SLOW_MHZ : `SRC_FAST_MHZ;
    wire   [5:0]  src_sum  = {1'b0, src_acc} + {1'b0, src_rate};
    wire   [5:0]  src_left = src_sum - {1'b0, `HCLK_MHZ};
    wire          src_wrap = src_sum >= {1'b0, `HCLK_MHZ};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            src_acc <= 5'h00;
            src_en  <= 1'b0;
        end
        else
        begin
            src_acc <= src_wrap ? src_left[4:0] : src_sum[4:0]; // R6
            src_en  <= src_wrap;
        end
    end

    // baud generator; a zero divisor behaves as one
    logic [15:0]  div_cnt;
    logic         tick16;
    wire  [15:0]  div_last = (divisor == 16'h0000) ? 16'h0000 :
                             divisor - 16'h0001;
    wire          div_hit  = div_cnt >= div_last;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_cnt <= 16'h0000;
            tick16  <= 1'b0;
        end
        else
        begin
            tick16 <= src_en && div_hit; // R22
            if (src_en)
                div_cnt <= div_hit ? 16'h0000 : div_cnt + 16'h0001; // R5
        end
    end

    // two fifos: entry 0 transmit, entry 1 receive
    logic [1:0]        f_clr;
    logic [1:0]        f_full;
    logic [1:0][9:0]   f_dout;
    logic [1:0][4:0]   f_cnt;
    wire  [1:0]        f_push;
    wire  [1:0]        f_pop;
    wire  [1:0][9:0]   f_din;
    // outside fifo mode each side holds a single character
    wire  [4:0]        f_cap = fcfg.en ? `FIFO_DEPTH : 5'h01;

    for (genvar i = 0; i < 2; i++)
    begin : g_fifo
        logic [9:0]  mem [16];
        logic [3:0]  wp;
        logic [3:0]  rp;
        logic [4:0]  cnt;
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                wp  <= 4'h0;
                rp  <= 4'h0;
                cnt <= 5'h00;
            end
            else if (f_clr[i])
            begin
                wp  <= 4'h0;
                rp  <= 4'h0;
                cnt <= 5'h00;
            end
            else
            begin
                wp  <= wp + {3'h0, f_push[i]};
                rp  <= rp + {3'h0, f_pop[i]};
                cnt <= cnt + {4'h0, f_push[i]} - {4'h0, f_pop[i]};
            end
        end
        always_ff @(posedge hclk)
        begin
            if (f_push[i])
                mem[wp] <= f_din[i];
        end
        assign f_dout[i] = mem[rp];
        assign f_cnt[i]  = cnt;
        assign f_full[i] = cnt >= f_cap; // R13 R20
    end

    // transmit and receive engines
    logic         tx_pop;
    logic         tx_busy;
    logic         rx_push;
    logic  [9:0]  rx_word;
    wire          tx_empty = f_cnt[0] == 5'h00;
    wire          fcr_mode = hwdata[`FCR_EN] != fcfg.en;

    assign f_push[0] = wr_data && !f_full[0]; // R10
    assign f_din[0]  = {2'b00, hwdata[7:0]};
    assign f_pop[0]  = tx_pop;
    assign f_push[1] = rx_push && !f_full[1]; // R16
    assign f_din[1]  = rx_word;
    assign f_pop[1]  = rd_data && (f_cnt[1] != 5'h00);
    assign f_clr[0]  = wr_fcr && (hwdata[`FCR_TXCLR] || fcr_mode);
    assign f_clr[1]  = wr_fcr && (hwdata[`FCR_RXCLR] || fcr_mode);

    uart_tx u_tx
    (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .tick       (tick16),
        .cfg        (lcr),
        .data_valid (!tx_empty),
        .data       (f_dout[0][7:0]),
        .pop        (tx_pop),
        .busy       (tx_busy),
        .txd        (txd)
    );

    uart_rx u_rx
    (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .tick       (tick16),
        .cfg        (lcr),
        .rxd        (rxd),
        .push       (rx_push),
        .word       (rx_word)
    );

    // line status: {framing, parity, overrun}, sticky until read
    logic  [2:0]  err;
    wire   [2:0]  err_set = rx_push ?
                  {rx_word[9], rx_word[8], f_full[1]} : 3'h0;

    // receive timeout: four idle characters with data waiting
    logic  [9:0]  tmo_cnt;
    wire          tmo_hit = tmo_cnt == `TMO_TICKS;
    wire          tmo_rst = rx_push || f_pop[1] || (f_cnt[1] == 5'h00);

    // interrupt causes and priority
    logic         thre;
    logic  [3:0]  irq_id;
    wire   [4:0]  trig_lvl = (fcfg.trig == 2'h0) ? `TRIG_L0 :
                             (fcfg.trig == 2'h1) ? `TRIG_L1 :
                             (fcfg.trig == 2'h2) ? `TRIG_L2 : `TRIG_L3;
    wire          ls_pend  = err != 3'h0;
    wire          rda_pend = fcfg.en ? (f_cnt[1] >= trig_lvl) :
                             (f_cnt[1] != 5'h00);
    wire          to_pend  = fcfg.en && tmo_hit;
    wire          thre_set = (tx_pop && f_cnt[0] == 5'h01) ||
                             (wr_ier && hwdata[`IER_THRE] &&
                              !ier[`IER_THRE] && tx_empty);
    wire          thre_clr = f_push[0] || (rd_iir && irq_id == `IID_THRE);

    assign irq_id = (ier[`IER_LS] && ls_pend)   ? `IID_LS :
                    (ier[`IER_RX] && rda_pend)  ? `IID_RDA :
                    (ier[`IER_RX] && to_pend)   ? `IID_TO :
                    (ier[`IER_THRE] && thre)    ? `IID_THRE :
                    `IID_NONE; // R4 R19

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            err     <= 3'h0;
            tmo_cnt <= 10'h000;
            thre    <= 1'b0;
            irq     <= 1'b0;
        end
        else
        begin
            err  <= (err & {3{!rd_lsr}}) | err_set; // R17 R19
            thre <= (thre && !thre_clr) || thre_set; // R12
            irq  <= irq_id != `IID_NONE; // R18
            if (tmo_rst)
                tmo_cnt <= 10'h000;
            else if (tick16 && !tmo_hit)
                tmo_cnt <= tmo_cnt + 10'h001;
        end
    end

    // register read values, sampled in the address phase
    wire   [7:0]  rx_byte = (f_cnt[1] != 5'h00) ? f_dout[1][7:0] : 8'h00;
    wire   [7:0]  lsr_val = {1'b0, tx_empty && !tx_busy, tx_empty, 1'b0,
                             err, f_cnt[1] != 5'h00};
    wire   [7:0]  rd_val  =
        (ap_ofs == `OFS_DATA) ? rx_byte :
        (ap_ofs == `OFS_IER)  ? {5'h00, ier} :
        (ap_ofs == `OFS_IIR)  ? {fcfg.en, fcfg.en, 2'h0, irq_id} :
        (ap_ofs == `OFS_LCR)  ? {2'h0, lcr} :
        (ap_ofs == `OFS_LSR)  ? lsr_val :
        (ap_ofs == `OFS_CLK)  ? {7'h00, src_sel} : 8'h00;
    wire  [31:0]  rd_word = (ap_ofs == `OFS_DIV) ? {16'h0000, divisor} :
                            {24'h00_0000, rd_val};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend   <= 1'b0;
            wr_ofs    <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_pend <= ahb_ap && hwrite;
            if (ahb_ap)
                wr_ofs <= ap_ofs;
            hrdata <= ap_rd ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ier     <= `IER_RST;
            lcr     <= line_cfg_t'(`LCR_RST);
            fcfg    <= fifo_cfg_t'(3'h0);
            divisor <= `DIV_RST;
            src_sel <= 1'b0;
        end
        else
        begin
            if (wr_ier)
                ier <= hwdata[2:0];
            if (wr_lcr)
                lcr <= line_cfg_t'(hwdata[5:0]); // R1 R2 R3
            if (wr_fcr)
                fcfg <= {hwdata[`FCR_TRIG], hwdata[`FCR_EN]}; // R13 R21
            if (wr_div)
                divisor <= hwdata[15:0]; // R5 R7 R8 R9
            if (wr_clk)
                src_sel <= hwdata[0]; // R6
        end
    end

    property p_src_fast;
        @(posedge hclk) disable iff (!hresetn)
        (!src_sel && $past(!src_sel) && $past(src_en) && !src_en)
            |=> src_en;
    endproperty
    a_src_fast: assert property (p_src_fast) // R6
        else $error("24 MHz source enable missed a step");

    property p_src_slow;
        @(posedge hclk) disable iff (!hresetn)
        (src_sel && $past(src_sel) && $past(src_sel, 2) &&
         src_en && $past(src_en)) |=> !src_en;
    endproperty
    a_src_slow: assert property (p_src_slow) // R6
        else $error("16 MHz source enable runs too fast");

    property p_prio;
        @(posedge hclk) disable iff (!hresetn)
        (ls_pend && ier[`IER_LS]) |-> (irq_id == `IID_LS) ##1 irq;
    endproperty
    a_prio: assert property (p_prio) // R4
        else $error("line status not reported first");

    property p_rda;
        @(posedge hclk) disable iff (!hresetn)
        (ier[`IER_RX] && !ls_pend && fcfg.en && f_cnt[1] >= trig_lvl)
            |-> (irq_id == `IID_RDA);
    endproperty
    a_rda: assert property (p_rda) // R21
        else $error("trigger level reached without data interrupt");

    property p_tx_push;
        @(posedge hclk) disable iff (!hresetn)
        (f_push[0] && !f_pop[0] && !f_clr[0])
            |=> (f_cnt[0] == $past(f_cnt[0]) + 5'h01);
    endproperty
    a_tx_push: assert property (p_tx_push) // R10
        else $error("transmit write not queued");

    property p_thre;
        @(posedge hclk) disable iff (!hresetn)
        (tx_pop && f_cnt[0] == 5'h01 && !f_clr[0]) |=> thre;
    endproperty
    a_thre: assert property (p_thre) // R12
        else $error("transmit empty flag not set");
endmodule : uart_top

//--- bench/serial_peer.sv
// behavioural serial device on the far side of the link
`timescale 1ns/1ps
module serial_peer
#(
    parameter int BIT_NS = 1000
)
(
    // link
    input  wire logic txd,
    output logic      rxd
);
    initial rxd = 1'b1;

    // start low, lsb first, optional parity, one stop level, one idle bit
    task automatic send(input logic [7:0] d, input int n, input logic pen,
                        input logic pb, input logic stp);
    begin
        rxd = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < n; i++)
        begin
            rxd = d[i];
            #(BIT_NS);
        end
        if (pen)
        begin
            rxd = pb;
            #(BIT_NS);
        end
        rxd = stp;
        #(BIT_NS);
        rxd = 1'b1;
        #(BIT_NS);
    end
    endtask : send

    // samples each bit in its middle; returns at mid first stop bit
    task automatic recv(input int n, input logic pen, output logic [7:0] d,
                        output logic pb, output logic stp);
    begin
        d = 8'h00;
        pb = 1'b0;
        @(negedge txd);
        #(BIT_NS / 2);
        for (int i = 0; i < n; i++)
        begin
            #(BIT_NS);
            d[i] = txd;
        end
        if (pen)
        begin
            #(BIT_NS);
            pb = txd;
        end
        #(BIT_NS);
        stp = txd;
    end
    endtask : recv
endmodule : serial_peer

//--- bench/tb_uart_top.sv
// self-checking bench of the uart: registers and serial traffic
`timescale 1ns/1ps
`include "uart_cfg.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_uart_top;
    logic        hclk, hresetn, hwrite, hreadyout, hresp, rxd, txd, irq;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata;
    int          errors = 0;
    int          checks_done = 0;
    // 16 MHz source, divisor 1: one bit is 25 hclk cycles
    logic [5:0]  lcr_tab [5] = '{6'h1C, 6'h05, 6'h0A, 6'h2F, 6'h3B};

    uart_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .hwrite(hwrite), .htrans(htrans), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd), .irq(irq));
    serial_peer peer (.txd(txd), .rxd(rxd));

    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rdv);
    begin
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(a, 1'b1, d, x);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        logic [31:0] v;
        xfer(a, 1'b0, 32'h0000_0000, v);
        `CHK(nm, e, v)
        `CHK("bus response", 2'b10, {hreadyout, hresp})
    endtask : rc

    // bounded poll until a received character is ready
    task automatic wait_rx(output logic [31:0] v);
        v = 32'h0000_0000;
        for (int t = 0; t < 100 && v[0] !== 1'b1; t++)
            xfer(`OFS_LSR, 1'b0, 32'h0000_0000, v);
    endtask : wait_rx

    function automatic logic exp_par(input logic [5:0] c,
                                     input logic [7:0] d);
        return c[5] ? ~c[4] : (^d) ^ ~c[4];
    endfunction : exp_par

    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    initial
    begin
        #(600_000);
        errors++;
        $display("watchdog expired");
        complete_run();
    end

    initial
    begin
        logic [5:0]  c;
        logic [7:0]  m, d, g;
        logic        pb, st;
        logic [31:0] v;
        hresetn = 1'b0;
        haddr = 32'h0000_0000;
        hwrite = 1'b0;
        htrans = 2'h0;
        hwdata = 32'h0000_0000;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(`OFS_LCR, 32'h0000_0003, "lcr reset");
        rc(`OFS_IER, 32'h0000_0000, "ier reset");
        rc(`OFS_DIV, 32'h0000_0001, "div reset");
        rc(`OFS_LSR, 32'h0000_0060, "lsr reset");
        rc(8'h1C, 32'h0000_0000, "unmapped");
        wr(`OFS_DIV, 32'h0000_FFFF);
        rc(`OFS_DIV, 32'h0000_FFFF, "div max");
        wr(`OFS_DIV, 32'h0000_0001);
        wr(`OFS_CLK, 32'h0000_0001);
        rc(`OFS_CLK, 32'h0000_0001, "clk sel");
        $display("test registers done");
        for (int i = 0; i < 5; i++)
        begin
            c = lcr_tab[i];
            m = 8'hFF >> (3 - c[1:0]);
            d = 8'h96 ^ i[7:0];
            wr(`OFS_LCR, {26'h000_0000, c});
            fork
                peer.recv(5 + c[1:0], c[3], g, pb, st);
                wr(`OFS_DATA, {24'h00_0000, d});
            join
            `CHK("tx data", d & m, g)
            if (c[3])
                `CHK("tx parity", exp_par(c, d & m), pb)
            `CHK("tx stop", 1'b1, st)
            peer.send(d, 5 + c[1:0], c[3], exp_par(c, d & m), 1'b1);
            wait_rx(v);
            `CHK("rx flags", 4'h1, v[3:0])
            rc(`OFS_DATA, {24'h00_0000, d & m}, "rx data");
        end
        $display("test formats done");
        wr(`OFS_IER, 32'h0000_0004);
        for (int j = 0; j < 2; j++)
        begin
            peer.send(8'h5A, 8, 1'b1, ~j[0], j[0] ^ 1'b1);
            @(posedge hclk);
            rc(`OFS_IIR, 32'h0000_0001, "id line status");
            wait_rx(v);
            `CHK("rx error", j[0] ? 4'h9 : 4'h5, v[3:0])
            rc(`OFS_DATA, 32'h0000_005A, "rx err data");
        end
        $display("test errors done");
        wr(`OFS_IIR, 32'h0000_0041);
        wr(`OFS_IER, 32'h0000_0001);
        fork
            for (int k = 0; k < 3; k++)
            begin
                peer.recv(8, 1'b1, g, pb, st);
                `CHK("fifo tx", 8'h61 + k[7:0], g)
            end
            for (int k = 0; k < 3; k++)
                wr(`OFS_DATA, 32'h0000_0061 + k);
        join
        for (int k = 0; k < 4; k++)
        begin
            `CHK("irq below trigger", 1'b0, irq)
            peer.send(8'h30 + k[7:0], 8, 1'b1, 1'b0, 1'b1);
        end
        repeat (8) @(posedge hclk);
        `CHK("irq at trigger", 1'b1, irq)
        wr(`OFS_IER, 32'h0000_0003);
        rc(`OFS_IIR, 32'h0000_00C2, "id rx first");
        for (int k = 0; k < 4; k++)
            rc(`OFS_DATA, 32'h0000_0030 + k, "fifo rx");
        rc(`OFS_IIR, 32'h0000_00C4, "id tx empty");
        rc(`OFS_IIR, 32'h0000_00C0, "id none");
        // one char below trigger, then more than four idle chars
        peer.send(8'h3F, 8, 1'b1, 1'b0, 1'b1);
        repeat (1100) @(posedge hclk);
        rc(`OFS_IIR, 32'h0000_00C3, "id timeout");
        rc(`OFS_DATA, 32'h0000_003F, "timeout data");
        repeat (2) @(posedge hclk);
        `CHK("irq idle", 1'b0, irq)
        $display("test fifo done");
        complete_run();
    end
endmodule : tb_uart_top
